//--- hdl/usart_sync_pkg.sv
// constants, field layout and carrier types for the synchronous serial port
// assumes a 32-bit apb master and a 200 MHz mclk
package usart_sync_pkg;

  // ****************************************
  // bus and register map
  // ****************************************
  localparam int         ADDR_W           = 10;
  localparam int         DATA_W           = 32;
  // printed offsets are register indexes; byte address is four times each
  localparam logic [7:0] IDX_GLOBAL_IRQ   = 8'h0B;
  localparam logic [7:0] IDX_FLAG_BANK    = 8'h0C;
  localparam logic [7:0] IDX_RX_STATUS    = 8'h18;
  localparam logic [7:0] IDX_TX_BUFFER    = 8'h19;
  localparam logic [7:0] IDX_RX_BUFFER    = 8'h1A;
  localparam logic [7:0] IDX_ENABLE_BANK  = 8'h8C;
  localparam logic [7:0] IDX_TX_STATUS    = 8'h98;
  localparam logic [7:0] IDX_BAUD_DIVISOR = 8'h99;

  // ****************************************
  // field positions
  // ****************************************
  // global_interrupt_control
  localparam int GIE_BIT    = 7;
  localparam int PERIPHERAL_IRQ_GATE_BIT   = 6;
  // peripheral_flag_bank / peripheral_enable_bank
  localparam int RX_FLAG_BIT = 5;
  localparam int TX_FLAG_BIT = 4;
  // receive_status_control
  localparam int PORT_EN_BIT = 7;
  localparam int RX9_BIT     = 6;
  localparam int SINGLE_RECEIVE_ENABLE_BIT    = 5;
  localparam int CONTINUOUS_RECEIVE_ENABLE_BIT    = 4;
  localparam int ADDR_DET_BIT = 3;
  localparam int FRAME_BIT   = 2;
  localparam int OVERRUN_BIT = 1;
  localparam int NINTH_RECEIVED_BIT_BIT    = 0;
  // transmit_status_control
  localparam int CLOCK_SOURCE_SELECT_BIT    = 7;
  localparam int TX9_BIT     = 6;
  localparam int TRANSMIT_ENABLE_BIT    = 5;
  localparam int SYNC_BIT    = 4;
  localparam int HIGH_BAUD_SELECT_BIT    = 2;
  localparam int SHIFTER_EMPTY_BIT    = 1;
  localparam int NINTH_TRANSMIT_BIT_BIT    = 0;

  // ****************************************
  // reset values and counts
  // ****************************************
  localparam logic [7:0]  REG_RESET      = 8'h00;
  localparam logic [7:0]  TX_STATUS_RST  = 8'h02;
  localparam logic [3:0]  BITS_SHORT     = 4'h8;
  localparam logic [3:0]  BITS_LONG      = 4'h9;
  localparam int          FIFO_DEPTH     = 2;
  localparam logic [15:0] IRQ_VECTOR     = 16'h0004;

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic       ninth;
    logic [7:0] data;
  } rx_word_s;

  typedef struct packed {
    logic out;
    logic oe_b;
  } pin_drive_s;

  typedef enum logic [1:0] {
    LINK_IDLE = 2'b00,
    LINK_RX   = 2'b01,
    LINK_TX   = 2'b10
  } link_mode_e;

endpackage

//--- hdl/usart_sync.sv
// synchronous half-duplex serial port: master/slave receive, transmit, apb registers
// assumes apb master on mclk; serial pins resolved outside from out/oe_b
//
// Contract
// RULE1: master mode: either receive enable starts reception
// RULE2: sample data on shift clock falling edge
// RULE3: single-receive enable takes exactly one word
// RULE4: continuous enable receives until software clears
// RULE5: both enables set means continuous reception
// RULE6: finished word goes to fifo, sets flag
// RULE7: receive irq only when its enable set
// RULE8: receive flag read-only, clears when fifo empty
// RULE9: two-word fifo, third shifts, ordered reads
// RULE10: full fifo at word end: overrun, drop
// RULE11: overrun cleared only by clearing continuous enable
// RULE12: overrun blocks all moves into fifo
// RULE13: ninth bit buffered; read updates status field
// RULE14: software reads status before data register
// RULE15: software setup order for master reception
// RULE16: clock source clear: slave, external clock
// RULE17: slave transfers behave as master ones
// RULE18: slave keeps shifting while core sleeps
// RULE19: second word waits, transmit flag clear
// RULE20: second word moves, then transmit flag sets
// RULE21: enabled flag wakes core; vector 0004h
// RULE22: slave mode ignores single-receive enable
// RULE23: slave continuous receive during sleep wakes core
// RULE24: software setup order for slave transmission
// RULE25: master drives its own shift clock out
// RULE26: baud generator held reset when all idle
// RULE27: single word done clears enable, resumes transmit
// RULE28: external shift clock synchronised, edges detected
// RULE29: eight bits, or nine in nine-bit mode
`timescale 1ns/100ps

module usart_sync
  import usart_sync_pkg::*;
(
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_b,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  // serial clock pin
  input  wire logic              serial_clock_in,
  output pin_drive_s             serial_clock_pin,
  // serial data pin
  input  wire logic              serial_data_in,
  output pin_drive_s             serial_data_pin,
  // core
  input  wire logic              core_sleep,
  output logic                   core_wake,
  output logic                   core_irq,
  output logic      [15:0]       irq_vector
);

  // ****************************************
  // register state
  // ****************************************
  logic [1:0]  gic_r;
  logic [7:0]  enable_bank_r;
  logic        port_en_r;
  logic        rx9_r;
  logic        single_receive_enable_r;
  logic        continuous_receive_enable_r;
  logic        addr_det_r;
  logic        overrun_r;
  logic        clock_source_select_r;
  logic        tx9_r;
  logic        transmit_enable_r;
  logic        sync_r;
  logic        high_baud_select_r;
  logic        ninth_transmit_bit_r;
  logic [7:0]  baud_divisor_r;
  logic [7:0]  txbuf_r;
  logic        txbuf_full_r;

  // ****************************************
  // apb decode
  // ****************************************
  logic        access;
  logic        wr;
  logic        rd;
  logic [7:0]  idx;
  logic        mapped;
  logic        wr_gic;
  logic        wr_rxs;
  logic        wr_txb;
  logic        wr_en;
  logic        wr_txs;
  logic        wr_baud;
  logic        rd_rxb;
  logic [7:0]  rd_byte;

  assign access  = psel & penable & pready;
  assign wr      = access & pwrite & mapped;
  assign rd      = access & ~pwrite & mapped;
  assign idx     = paddr[ADDR_W-1:2];
  assign mapped  = (paddr[1:0] == 2'h0) &
                   (idx == IDX_GLOBAL_IRQ  || idx == IDX_FLAG_BANK   ||
                    idx == IDX_RX_STATUS   || idx == IDX_TX_BUFFER   ||
                    idx == IDX_RX_BUFFER   || idx == IDX_ENABLE_BANK ||
                    idx == IDX_TX_STATUS   || idx == IDX_BAUD_DIVISOR);
  assign wr_gic  = wr & (idx == IDX_GLOBAL_IRQ);
  assign wr_rxs  = wr & (idx == IDX_RX_STATUS);
  assign wr_txb  = wr & (idx == IDX_TX_BUFFER);
  assign wr_en   = wr & (idx == IDX_ENABLE_BANK);
  assign wr_txs  = wr & (idx == IDX_TX_STATUS);
  assign wr_baud = wr & (idx == IDX_BAUD_DIVISOR);
  assign rd_rxb  = rd & (idx == IDX_RX_BUFFER);

  // ****************************************
  // link control
  // ****************************************
  logic        link_on;
  logic        rx_en;
  logic        tx_go;
  logic [3:0]  rx_bits;
  logic [3:0]  tx_bits;
  link_mode_e  mode_r;

  assign link_on = port_en_r & sync_r;
  assign rx_en   = link_on & (continuous_receive_enable_r | (single_receive_enable_r & clock_source_select_r)); // RULE1 RULE5 RULE22
  assign tx_go   = link_on & transmit_enable_r & ~rx_en;
  assign rx_bits = rx9_r ? BITS_LONG : BITS_SHORT; // RULE29
  assign tx_bits = tx9_r ? BITS_LONG : BITS_SHORT; // RULE29

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      mode_r <= LINK_IDLE;
    end else begin
      case ({rx_en, tx_go})
        2'b10:   mode_r <= LINK_RX;
        2'b01:   mode_r <= LINK_TX;
        default: mode_r <= LINK_IDLE;
      endcase
    end
  end

  // ****************************************
  // baud generator and clock selection
  // ****************************************
  logic        brg_run;
  logic [7:0]  brg_cnt_r;
  logic        gen_clk_r;
  logic        ext_sync1_r;
  logic        ext_sync2_r;
  logic        sclk_now;
  logic        sclk_prev_r;
  logic        sclk_rise;
  logic        sclk_fall;

  assign brg_run = link_on & clock_source_select_r & (transmit_enable_r | continuous_receive_enable_r | single_receive_enable_r); // RULE26

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      brg_cnt_r <= 8'h00;
      gen_clk_r <= 1'b0;
    end else if (!brg_run) begin
      brg_cnt_r <= 8'h00; // RULE26
      gen_clk_r <= 1'b0;
    end else if (brg_cnt_r == baud_divisor_r) begin
      brg_cnt_r <= 8'h00;
      gen_clk_r <= ~gen_clk_r; // RULE25
    end else begin
      brg_cnt_r <= brg_cnt_r + 8'h01;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ext_sync1_r <= 1'b0;
      ext_sync2_r <= 1'b0;
      sclk_prev_r <= 1'b0;
    end else begin
      ext_sync1_r <= serial_clock_in; // RULE28
      ext_sync2_r <= ext_sync1_r;
      sclk_prev_r <= sclk_now;
    end
  end

  assign sclk_now  = clock_source_select_r ? gen_clk_r : ext_sync2_r; // RULE16 RULE18
  assign sclk_rise = sclk_now & ~sclk_prev_r; // RULE28
  assign sclk_fall = ~sclk_now & sclk_prev_r; // RULE17

  // ****************************************
  // receive shifter
  // ****************************************
  logic [8:0]  rsr_r;
  logic [3:0]  rx_cnt_r;
  logic [8:0]  rsr_shift;
  logic        rx_sample;
  logic        word_done;
  rx_word_s    word_in;

  assign rx_sample = rx_en & sclk_fall; // RULE2
  assign rsr_shift = {serial_data_in, rsr_r[8:1]};
  assign word_done = rx_sample & (rx_cnt_r + 4'h1 == rx_bits); // RULE29
  assign word_in   = rx9_r ? rsr_shift : {1'b0, rsr_shift[8:1]}; // RULE13

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rsr_r    <= 9'h000;
      rx_cnt_r <= 4'h0;
    end else if (!rx_en) begin
      rx_cnt_r <= 4'h0;
    end else if (rx_sample) begin
      rsr_r    <= rsr_shift; // RULE2
      rx_cnt_r <= word_done ? 4'h0 : rx_cnt_r + 4'h1; // RULE4
    end
  end

  // ****************************************
  // receive fifo
  // ****************************************
  rx_word_s    fifo_mem [FIFO_DEPTH];
  logic        wr_ptr_r;
  logic        rd_ptr_r;
  logic [1:0]  fifo_cnt_r;
  logic        fifo_full;
  logic        push;
  logic        pop;
  logic        overrun_set;
  rx_word_s    fifo_head;

  assign fifo_full   = (fifo_cnt_r == 2'(FIFO_DEPTH)); // RULE9
  assign push        = word_done & ~overrun_r & ~fifo_full; // RULE6 RULE12
  assign overrun_set = word_done & ~overrun_r & fifo_full; // RULE10
  assign pop         = rd_rxb & (fifo_cnt_r != 2'h0); // RULE9
  assign fifo_head   = (fifo_cnt_r != 2'h0) ? fifo_mem[rd_ptr_r] : '0;

  always_ff @(posedge mclk) begin
    if (push) begin
      fifo_mem[wr_ptr_r] <= word_in; // RULE6 RULE13
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_r   <= 1'b0;
      rd_ptr_r   <= 1'b0;
      fifo_cnt_r <= 2'h0;
    end else begin
      wr_ptr_r   <= wr_ptr_r ^ push;
      rd_ptr_r   <= rd_ptr_r ^ pop; // RULE13
      fifo_cnt_r <= fifo_cnt_r + {1'b0, push} - {1'b0, pop}; // RULE8
    end
  end

  // ****************************************
  // transmit shifter
  // ****************************************
  logic [8:0]  tsr_r;
  logic        tsr_full_r;
  logic [3:0]  tx_cnt_r;
  logic        tsr_load;
  logic        tx_shift;
  logic        dout_r;

  assign tsr_load = transmit_enable_r & ~tsr_full_r & txbuf_full_r; // RULE19 RULE20
  assign tx_shift = tx_go & tsr_full_r & sclk_rise;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tsr_r      <= 9'h000;
      tsr_full_r <= 1'b0;
      tx_cnt_r   <= 4'h0;
      dout_r     <= 1'b0;
    end else if (!transmit_enable_r) begin
      tsr_full_r <= 1'b0;
      tx_cnt_r   <= 4'h0;
    end else if (tsr_load) begin
      tsr_r      <= {ninth_transmit_bit_r, txbuf_r}; // RULE19
      tsr_full_r <= 1'b1;
      tx_cnt_r   <= 4'h0;
    end else if (tx_shift) begin
      if (tx_cnt_r == tx_bits) begin
        tsr_full_r <= 1'b0; // RULE20
      end else begin
        dout_r   <= tsr_r[0];
        tsr_r    <= {1'b0, tsr_r[8:1]};
        tx_cnt_r <= tx_cnt_r + 4'h1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      txbuf_r      <= REG_RESET;
      txbuf_full_r <= 1'b0;
    end else if (wr_txb) begin
      txbuf_r      <= pwdata[7:0];
      txbuf_full_r <= 1'b1;
    end else if (tsr_load) begin
      txbuf_full_r <= 1'b0; // RULE20
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  logic        single_receive_enable_done;
  logic        continuous_receive_enable_nxt;

  assign single_receive_enable_done = word_done & single_receive_enable_r & ~continuous_receive_enable_r & clock_source_select_r; // RULE3 RULE27
  assign continuous_receive_enable_nxt  = wr_rxs ? pwdata[CONTINUOUS_RECEIVE_ENABLE_BIT] : continuous_receive_enable_r;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      port_en_r  <= 1'b0;
      rx9_r      <= 1'b0;
      single_receive_enable_r     <= 1'b0;
      continuous_receive_enable_r     <= 1'b0;
      addr_det_r <= 1'b0;
    end else if (wr_rxs) begin
      port_en_r  <= pwdata[PORT_EN_BIT];
      rx9_r      <= pwdata[RX9_BIT];
      single_receive_enable_r     <= pwdata[SINGLE_RECEIVE_ENABLE_BIT];
      continuous_receive_enable_r     <= pwdata[CONTINUOUS_RECEIVE_ENABLE_BIT]; // RULE4
      addr_det_r <= pwdata[ADDR_DET_BIT];
    end else if (single_receive_enable_done) begin
      single_receive_enable_r     <= 1'b0; // RULE27
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      overrun_r <= 1'b0;
    end else begin
      overrun_r <= overrun_set | (overrun_r & continuous_receive_enable_nxt); // RULE10 RULE11
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      {clock_source_select_r, tx9_r, transmit_enable_r, sync_r} <= TX_STATUS_RST[7:4];
      high_baud_select_r <= TX_STATUS_RST[HIGH_BAUD_SELECT_BIT];
      ninth_transmit_bit_r <= TX_STATUS_RST[NINTH_TRANSMIT_BIT_BIT];
    end else if (wr_txs) begin
      {clock_source_select_r, tx9_r, transmit_enable_r, sync_r} <= pwdata[7:4]; // RULE16
      high_baud_select_r <= pwdata[HIGH_BAUD_SELECT_BIT];
      ninth_transmit_bit_r <= pwdata[NINTH_TRANSMIT_BIT_BIT];
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      gic_r          <= 2'h0;
      enable_bank_r  <= REG_RESET;
      baud_divisor_r <= REG_RESET;
    end else begin
      if (wr_gic) gic_r <= {pwdata[GIE_BIT], pwdata[PERIPHERAL_IRQ_GATE_BIT]};
      if (wr_en) enable_bank_r <= pwdata[7:0];
      if (wr_baud) baud_divisor_r <= pwdata[7:0];
    end
  end

  // ****************************************
  // flags and read mux
  // ****************************************
  logic        rx_flag;
  logic        tx_flag;
  logic        flag_irq;
  logic [7:0]  flag_bank;
  logic [7:0]  rx_status;
  logic [7:0]  tx_status;

  assign rx_flag  = (fifo_cnt_r != 2'h0); // RULE6 RULE8
  assign tx_flag  = ~txbuf_full_r; // RULE19 RULE20
  assign flag_irq = (rx_flag & enable_bank_r[RX_FLAG_BIT]) | // RULE7
                    (tx_flag & enable_bank_r[TX_FLAG_BIT]);

  assign flag_bank = (8'(rx_flag) << RX_FLAG_BIT) | (8'(tx_flag) << TX_FLAG_BIT);
  assign rx_status = {port_en_r, rx9_r, single_receive_enable_r, continuous_receive_enable_r, addr_det_r,
                      1'b0, overrun_r, fifo_head.ninth}; // RULE13 RULE14
  assign tx_status = {clock_source_select_r, tx9_r, transmit_enable_r, sync_r, 1'b0, high_baud_select_r,
                      ~tsr_full_r, ninth_transmit_bit_r};

  always_comb begin
    case (idx)
      IDX_GLOBAL_IRQ:   rd_byte = {gic_r, 6'h00};
      IDX_FLAG_BANK:    rd_byte = flag_bank;
      IDX_RX_STATUS:    rd_byte = rx_status;
      IDX_TX_BUFFER:    rd_byte = txbuf_r;
      IDX_RX_BUFFER:    rd_byte = fifo_head.data; // RULE9
      IDX_ENABLE_BANK:  rd_byte = enable_bank_r;
      IDX_TX_STATUS:    rd_byte = tx_status;
      IDX_BAUD_DIVISOR: rd_byte = baud_divisor_r;
      default:          rd_byte = 8'h00;
    endcase
  end

  // ****************************************
  // apb answer: one wait cycle
  // ****************************************
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      prdata  <= (psel & penable & ~pready & mapped) ? {24'h00_0000, rd_byte}
                                                   : 32'h0000_0000;
    end
  end

  // ****************************************
  // pins and core signals
  // ****************************************
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      serial_clock_pin <= '{out: 1'b0, oe_b: 1'b1};
      serial_data_pin  <= '{out: 1'b0, oe_b: 1'b1};
    end else begin
      serial_clock_pin.out  <= gen_clk_r; // RULE25
      serial_clock_pin.oe_b <= ~(link_on & clock_source_select_r & (transmit_enable_r | rx_en)); // RULE16
      serial_data_pin.out   <= dout_r;
      serial_data_pin.oe_b  <= ~(mode_r == LINK_TX);
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      core_wake  <= 1'b0;
      core_irq   <= 1'b0;
      irq_vector <= 16'h0000;
    end else begin
      core_wake  <= core_sleep & flag_irq; // RULE21 RULE23
      core_irq   <= gic_r[1] & gic_r[0] & flag_irq; // RULE7
      irq_vector <= (gic_r[1] & gic_r[0] & flag_irq) ? IRQ_VECTOR : 16'h0000; // RULE21
    end
  end

endmodule

//--- testbench/usart_sync_asserts.sv
// apb and core-output assertions for the serial port
// assumes binding to usart_sync, one mclk domain
`timescale 1ns/100ps
module usart_sync_asserts
  import usart_sync_pkg::*;
(
  // clock and reset
  input wire logic              mclk,
  input wire logic              rst_b,
  // apb
  input wire logic              psel,
  input wire logic              penable,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // clock pin
  input wire pin_drive_s        serial_clock_pin,
  // core
  input wire logic              core_sleep,
  input wire logic              core_wake,
  input wire logic              core_irq,
  input wire logic [15:0]       irq_vector
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence first_acc_s;
    psel && penable && !pready;
  endsequence
  sequence answer_s;
    pready ##1 !pready;
  endsequence
  wait_state_a: assert property (first_acc_s |=> answer_s)
    else $error("answer not after one wait state");
  ready_req_a: assert property (pready |-> psel && penable && $past(psel && penable))
    else $error("ready without access");
  slverr_ready_a: assert property (pslverr |-> pready)
    else $error("error outside answer");
  misalign_err_a: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned access not refused");
  upper_zero_a: assert property (pready |-> prdata[DATA_W-1:8] == '0)
    else $error("upper read bits not zero");
  vector_on_a: assert property (core_irq |-> irq_vector == IRQ_VECTOR)
    else $error("vector missing with irq");
  vector_off_a: assert property (!core_irq |-> irq_vector == 16'h0000)
    else $error("vector without irq");
  wake_sleep_a: assert property (core_wake |-> $past(core_sleep))
    else $error("wake while awake");
  brg_idle_a: assert property (serial_clock_pin.oe_b && $past(serial_clock_pin.oe_b)
    |-> !serial_clock_pin.out)
    else $error("shift clock runs while idle");
endmodule

bind usart_sync usart_sync_asserts usart_sync_asserts_i (
  .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_sleep(core_sleep),
  .serial_clock_pin(serial_clock_pin),
  .core_wake(core_wake), .core_irq(core_irq), .irq_vector(irq_vector)
);

//--- testbench/serial_peer.sv
// far-side serial device: shifts a stream out, captures bits, makes slave clock
// assumes resolved line clock and data from the bench
`timescale 1ns/100ps
module serial_peer #(
  parameter int HALF = 8
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // line
  input  wire logic        line_clk,
  input  wire logic        line_data,
  output logic             clk_out,
  output logic             data_out,
  // control
  input  wire logic [31:0] stream_in,
  input  wire logic        load,
  input  wire logic        go,
  input  wire logic [7:0]  pulses,
  output logic [7:0]       got
);
  logic       lc_q;
  logic       started;
  logic [31:0] sr;
  logic [3:0] cnt;
  logic [8:0] left;
  logic [7:0] ph;
  assign data_out = sr[0];
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      lc_q <= 1'h0; started <= 1'h0; sr <= '0; cnt <= '0;
      got <= '0; left <= '0; ph <= '0; clk_out <= 1'h0;
    end else begin
      lc_q <= line_clk;
      if (load) begin
        sr <= stream_in; started <= 1'h0; cnt <= '0;
      end else if (lc_q && !line_clk) begin
        started <= 1'h0 | 1'h1;
        if (cnt < 4'h8) begin
          got <= {line_data, got[7:1]};
          cnt <= cnt + 4'h1;
        end
      end else if (!lc_q && line_clk && started) begin
        sr <= {~sr[0], sr[31:1]}; // spent bits refill with a changing pattern
      end
      if (go) begin
        left <= {pulses, 1'h0}; ph <= '0;
      end else if (left != 9'h0) begin
        if (ph == 8'(HALF - 1)) begin
          ph <= '0; clk_out <= ~clk_out; left <= left - 9'h1;
        end else begin
          ph <= ph + 8'h1;
        end
      end
    end
  end
endmodule

//--- testbench/usart_sync_tb.sv
// self-checking bench for the serial port: registers, receive, slave sleep
// assumes serial_peer and the bound checker
`timescale 1ns/100ps
module usart_sync_tb
  import usart_sync_pkg::*;
;
  logic mclk, rst_b, psel, penable, pwrite, pready, pslverr, core_sleep, load, go;
  logic core_wake, core_irq, peer_clk, peer_dat, clk_w, dat_w, err;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata;
  logic [15:0] irq_vector;
  pin_drive_s clk_pin, dat_pin;
  logic [31:0] stream, seed;
  logic [7:0] pulses, got, rd;
  logic [8:0] w;
  logic [8:0] exp_q[$];
  logic [7:0] ridx[8] = '{IDX_GLOBAL_IRQ, IDX_FLAG_BANK, IDX_RX_STATUS, IDX_TX_BUFFER,
                          IDX_RX_BUFFER, IDX_ENABLE_BANK, IDX_TX_STATUS, IDX_BAUD_DIVISOR};
  logic [7:0] rrst[8] = '{8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00};
  int mismatches, n_tests, n;
  int cyc = 0;
  assign clk_w = clk_pin.oe_b ? peer_clk : clk_pin.out;
  assign dat_w = dat_pin.oe_b ? peer_dat : dat_pin.out;
  usart_sync usart_sync_i (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_clock_in(clk_w), .serial_clock_pin(clk_pin),
    .serial_data_in(dat_w), .serial_data_pin(dat_pin), .core_sleep(core_sleep),
    .core_wake(core_wake), .core_irq(core_irq), .irq_vector(irq_vector));
  serial_peer serial_peer_i (.mclk(mclk), .rst_b(rst_b), .line_clk(clk_w),
    .line_data(dat_w), .clk_out(peer_clk), .data_out(peer_dat), .stream_in(stream),
    .load(load), .go(go), .pulses(pulses), .got(got));
  // ****************************************
  // tasks
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [8:0] g, input logic [8:0] e);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic wr, input logic [9:0] a, input logic [7:0] d);
    @(posedge mclk);
    psel <= 1'h1; pwrite <= wr; paddr <= a; pwdata <= {24'h0, d};
    @(posedge mclk);
    penable <= 1'h1;
    do @(posedge mclk); while (pready !== 1'h1);
    rd = prdata[7:0]; err = pslverr;
    psel <= 1'h0; penable <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    apb(1'h1, {i, 2'h0}, d);
  endtask
  task automatic rdc(input logic [7:0] i, input logic [7:0] m, input logic [7:0] e);
    apb(1'h0, {i, 2'h0}, 8'h00);
    chk({1'h0, rd & m}, {1'h0, e});
  endtask
  task automatic poll(input logic [7:0] i, input int b);
    int k;
    k = 0;
    do begin apb(1'h0, {i, 2'h0}, 8'h00); k++; end while (rd[b] !== 1'h1 && k < 200);
    chk({8'h0, rd[b]}, 9'h001);
  endtask
  task automatic kick(input logic [31:0] s, input logic [7:0] p);
    stream <= s; pulses <= p; load <= 1'h1; go <= (p != 8'h0);
    @(posedge mclk);
    load <= 1'h0; go <= 1'h0;
  endtask
  task automatic wake_wait;
    n = 0;
    while (core_wake !== 1'h1 && n < 2000) begin @(posedge mclk); n++; end
    chk({8'h0, core_wake}, 9'h001);
  endtask
  task finish_test;
    $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ****************************************
  // clock, timeout, sequence
  // ****************************************
  initial begin
    mclk = 1'h0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin mismatches++; finish_test; end
  end
  initial begin
    rst_b = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0; paddr = '0; pwdata = '0;
    core_sleep = 1'h0; load = 1'h0; go = 1'h0; stream = '0; pulses = '0;
    seed = 32'h340F; mismatches = 0; n_tests = 0;
    repeat (10) @(posedge mclk);
    rst_b <= 1'h1;
    foreach (ridx[k]) rdc(ridx[k], 8'hFF, rrst[k]);
    apb(1'h0, 10'h031, 8'h00); chk({8'h0, err}, 9'h001);
    apb(1'h0, 10'h000, 8'h00); chk({8'h0, err}, 9'h001);
    wr(IDX_FLAG_BANK, 8'hFF); rdc(IDX_FLAG_BANK, 8'hFF, 8'h10);
    // master single word
    seed = lfsr(seed); kick(seed, 8'h00); exp_q.push_back({1'h0, seed[7:0]});
    wr(IDX_BAUD_DIVISOR, 8'h07); wr(IDX_TX_STATUS, 8'h90); wr(IDX_RX_STATUS, 8'h80);
    wr(IDX_RX_STATUS, 8'hA0);
    poll(IDX_FLAG_BANK, RX_FLAG_BIT);
    rdc(IDX_RX_STATUS, 8'h20, 8'h00);
    w = exp_q.pop_front(); rdc(IDX_RX_BUFFER, 8'hFF, w[7:0]);
    repeat (300) @(posedge mclk);
    rdc(IDX_FLAG_BANK, 8'hFF, 8'h10);
    // continuous nine-bit with overrun
    seed = lfsr(seed); kick(seed, 8'h00);
    exp_q.push_back(seed[8:0]); exp_q.push_back(seed[17:9]);
    wr(IDX_RX_STATUS, 8'hF0);
    poll(IDX_RX_STATUS, OVERRUN_BIT);
    repeat (2) begin
      w = exp_q.pop_front();
      rdc(IDX_RX_STATUS, 8'h01, {7'h0, w[8]});
      rdc(IDX_RX_BUFFER, 8'hFF, w[7:0]);
    end
    repeat (400) @(posedge mclk);
    rdc(IDX_FLAG_BANK, 8'h20, 8'h00);
    wr(IDX_RX_STATUS, 8'hF0); rdc(IDX_RX_STATUS, 8'h02, 8'h02);
    wr(IDX_RX_STATUS, 8'hC0); rdc(IDX_RX_STATUS, 8'h02, 8'h00);
    // slave receive while asleep
    wr(IDX_TX_STATUS, 8'h10); wr(IDX_RX_STATUS, 8'hA0);
    seed = lfsr(seed); kick(seed, 8'h08); repeat (200) @(posedge mclk);
    rdc(IDX_FLAG_BANK, 8'h20, 8'h00);
    wr(IDX_ENABLE_BANK, 8'h20); wr(IDX_GLOBAL_IRQ, 8'hC0); wr(IDX_RX_STATUS, 8'h90);
    core_sleep <= 1'h1; seed = lfsr(seed); kick(seed, 8'h08);
    wake_wait;
    chk({8'h0, core_irq}, 9'h001); chk({1'h0, irq_vector[7:0]}, {1'h0, IRQ_VECTOR[7:0]});
    core_sleep <= 1'h0;
    rdc(IDX_RX_BUFFER, 8'hFF, seed[7:0]);
    // slave transmit while asleep
    wr(IDX_RX_STATUS, 8'h80); wr(IDX_ENABLE_BANK, 8'h10); wr(IDX_TX_STATUS, 8'h30);
    seed = lfsr(seed); wr(IDX_TX_BUFFER, seed[7:0]); wr(IDX_TX_BUFFER, seed[15:8]);
    rdc(IDX_FLAG_BANK, 8'h10, 8'h00);
    core_sleep <= 1'h1; kick(32'h0, 8'h09);
    wake_wait;
    repeat (40) @(posedge mclk);
    chk({1'h0, got}, {1'h0, seed[7:0]});
    rdc(IDX_FLAG_BANK, 8'h10, 8'h10);
    finish_test;
  end
endmodule
